// File: include/esf_defs.svh
// offsets, field positions and reset values of the event status flags
`ifndef ESF_DEFS_SVH
`define ESF_DEFS_SVH

`define ESF_ADDR_W 8
`define ESF_OFS_OVERCURRENT 8'h1D
`define ESF_OFS_PIN 8'h1E
`define ESF_OFS_CMP_WAKE 8'h1F
`define ESF_OFS_MASK 8'h20

`define ESF_BIT_OC 15
`define ESF_PIN_COUNT 13
`define ESF_BIT_USB 15
`define ESF_BIT_ADAPTOR 14
`define ESF_BIT_BATTERY 13
`define ESF_BIT_JACK_L 11
`define ESF_BIT_JACK_R 10
`define ESF_BIT_MIC_SHORT 9
`define ESF_BIT_MIC_PRES 8
`define ESF_BIT_FROM_OFF 6
`define ESF_BIT_FROM_HIB 5
`define ESF_BIT_CONV_FAULT 4
`define ESF_BIT_HEARTBEAT 3
`define ESF_BIT_POWER_PIN 2
`define ESF_BIT_ON_KEY 1
`define ESF_BIT_WAKE_PIN 0

`define ESF_MASK_OC 0
`define ESF_MASK_PIN 1
`define ESF_MASK_SUPPLY 2
`define ESF_MASK_AUDIO 3
`define ESF_MASK_WAKE 4
`define ESF_MASK_RESET 16'h001F
`define ESF_MASK_USED 16'h001F
`define ESF_FLAG_RESET 16'h0000

`endif

// File: include/esf_pkg.sv
// types of the event status flags
package esf_pkg;
  typedef struct packed {
    logic usb;
    logic adaptor;
    logic battery;
    logic jack_l;
    logic jack_r;
    logic mic_short;
    logic mic_pres;
  } esf_level_t;

  typedef struct packed {
    logic from_off;
    logic from_hib;
    logic conv_fault;
    logic heartbeat;
    logic power_pin;
    logic on_key;
    logic wake_pin;
  } esf_wake_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } esf_bus_t;
endpackage

// File: core/esf_event_status_flags.sv
// three read-to-clear event status registers and the group mask register
`timescale 1ns/1ps
`include "esf_defs.svh"

// Function
// R1: an overcurrent rising edge sets bit 15 of the register at 0x1d.
// R2: each flag stays set until a host read of its register clears it.
// R3: pin events 0 to 12 set bits 0 to 12 of 0x1e on the edge that each pin's trigger picks; here each flag sets while its pin_event bit is high.
// R4: any change of the usb, adaptor or battery feedback sets bits 15, 14 and 13 of 0x1f.
// R5: any change of the left or right jack detection sets bit 11 or bit 10.
// R6: either edge of mic short or mic presence detection sets bit 9 or bit 8.
// R7: a rise of the started-from-off indication sets bit 6.
// R8: a rise of the started-from-hibernate indication sets bit 5.
// R9: a rise of the converter-fault reset cause sets bit 4.
// R10: a rise of the missed-heartbeat reset cause sets bit 3.
// R11: a rise of the power pin hold indication sets bit 2.
// R12: a rise of the on-key hold indication sets bit 1.
// R13: a rise of the wake pin hold indication sets bit 0.
// R14: each source group has a mask bit, 0 passes its events and 1 suppresses them.
// R15: unassigned bits read as zero and ignore writes.
module esf_event_status_flags (
  input wire logic clock,
  input wire logic rst_b,
  input wire esf_pkg::esf_bus_t bus,
  input wire logic overcurrent,
  input wire logic [12:0] pin_event,
  input wire esf_pkg::esf_level_t level_in,
  input wire esf_pkg::esf_wake_t wake_in,
  output logic [15:0] rdata,
  output logic rvalid,
  output logic [4:0] group_pending
);

  // ----------------------------------------------------------------
  // input history for edge detection
  // ----------------------------------------------------------------
  logic oc_prev_q;
  logic oc_prev_d;
  esf_pkg::esf_level_t lvl_prev_q;
  esf_pkg::esf_level_t lvl_prev_d;
  esf_pkg::esf_wake_t wk_prev_q;
  esf_pkg::esf_wake_t wk_prev_d;

  always_comb begin
    oc_prev_d = overcurrent;
    lvl_prev_d = level_in;
    wk_prev_d = wake_in;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      oc_prev_q <= 1'b0;
      lvl_prev_q <= '0;
      wk_prev_q <= '0;
    end else begin
      oc_prev_q <= oc_prev_d;
      lvl_prev_q <= lvl_prev_d;
      wk_prev_q <= wk_prev_d;
    end
  end

  // ----------------------------------------------------------------
  // event set terms
  // ----------------------------------------------------------------
  logic [15:0] set_oc;
  logic [15:0] set_pin;
  logic [15:0] set_cw;
  esf_pkg::esf_level_t lvl_chg;
  esf_pkg::esf_wake_t wk_rise;

  always_comb begin
    lvl_chg = level_in ^ lvl_prev_q;
    wk_rise = wake_in & ~wk_prev_q;
    set_oc = 16'h0000;
    set_oc[`ESF_BIT_OC] = overcurrent & ~oc_prev_q; // [R1]
    set_pin = {3'h0, pin_event}; // [R3]
    set_cw = 16'h0000;
    set_cw[`ESF_BIT_USB] = lvl_chg.usb; // [R4]
    set_cw[`ESF_BIT_ADAPTOR] = lvl_chg.adaptor; // [R4]
    set_cw[`ESF_BIT_BATTERY] = lvl_chg.battery; // [R4]
    set_cw[`ESF_BIT_JACK_L] = lvl_chg.jack_l; // [R5]
    set_cw[`ESF_BIT_JACK_R] = lvl_chg.jack_r; // [R5]
    set_cw[`ESF_BIT_MIC_SHORT] = lvl_chg.mic_short; // [R6]
    set_cw[`ESF_BIT_MIC_PRES] = lvl_chg.mic_pres; // [R6]
    set_cw[`ESF_BIT_FROM_OFF] = wk_rise.from_off; // [R7]
    set_cw[`ESF_BIT_FROM_HIB] = wk_rise.from_hib; // [R8]
    set_cw[`ESF_BIT_CONV_FAULT] = wk_rise.conv_fault; // [R9]
    set_cw[`ESF_BIT_HEARTBEAT] = wk_rise.heartbeat; // [R10]
    set_cw[`ESF_BIT_POWER_PIN] = wk_rise.power_pin; // [R11]
    set_cw[`ESF_BIT_ON_KEY] = wk_rise.on_key; // [R12]
    set_cw[`ESF_BIT_WAKE_PIN] = wk_rise.wake_pin; // [R13]
  end

  // ----------------------------------------------------------------
  // status flags, mask and read port
  // ----------------------------------------------------------------
  logic [15:0] oc_q;
  logic [15:0] oc_d;
  logic [15:0] pin_q;
  logic [15:0] pin_d;
  logic [15:0] cw_q;
  logic [15:0] cw_d;
  logic [15:0] mask_q;
  logic [15:0] mask_d;
  logic [15:0] rdata_d;
  logic rvalid_d;
  logic [4:0] pend_d;
  logic rd_oc;
  logic rd_pin;
  logic rd_cw;
  logic [15:0] sup_bits;
  logic [15:0] aud_bits;

  always_comb begin
    rd_oc = 1'b0;
    rd_pin = 1'b0;
    rd_cw = 1'b0;
    rdata_d = 16'h0000;
    mask_d = mask_q;
    rvalid_d = bus.rd;
    if (bus.rd && bus.addr == `ESF_OFS_OVERCURRENT) begin
      rd_oc = 1'b1;
      rdata_d = oc_q;
    end else if (bus.rd && bus.addr == `ESF_OFS_PIN) begin
      rd_pin = 1'b1;
      rdata_d = pin_q;
    end else if (bus.rd && bus.addr == `ESF_OFS_CMP_WAKE) begin
      rd_cw = 1'b1;
      rdata_d = cw_q;
    end else if (bus.rd && bus.addr == `ESF_OFS_MASK) begin
      rdata_d = mask_q;
    end
    if (bus.wr && bus.addr == `ESF_OFS_MASK) begin
      mask_d = bus.wdata & `ESF_MASK_USED; // [R15]
    end
    // a read clears, but an event in the same cycle survives it
    oc_d = (rd_oc ? 16'h0000 : oc_q) | set_oc; // [R2]
    pin_d = (rd_pin ? 16'h0000 : pin_q) | set_pin; // [R2]
    cw_d = (rd_cw ? 16'h0000 : cw_q) | set_cw; // [R2]
    sup_bits = 16'h0000;
    sup_bits[`ESF_BIT_USB] = 1'b1;
    sup_bits[`ESF_BIT_ADAPTOR] = 1'b1;
    sup_bits[`ESF_BIT_BATTERY] = 1'b1;
    aud_bits = 16'h0F00;
    pend_d[`ESF_MASK_OC] = |oc_d & ~mask_d[`ESF_MASK_OC]; // [R14]
    pend_d[`ESF_MASK_PIN] = |pin_d & ~mask_d[`ESF_MASK_PIN]; // [R14]
    pend_d[`ESF_MASK_SUPPLY] = |(cw_d & sup_bits) & ~mask_d[`ESF_MASK_SUPPLY]; // [R14]
    pend_d[`ESF_MASK_AUDIO] = |(cw_d & aud_bits) & ~mask_d[`ESF_MASK_AUDIO]; // [R14]
    pend_d[`ESF_MASK_WAKE] = |(cw_d & 16'h007F) & ~mask_d[`ESF_MASK_WAKE]; // [R14]
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      oc_q <= `ESF_FLAG_RESET;
      pin_q <= `ESF_FLAG_RESET;
      cw_q <= `ESF_FLAG_RESET;
      mask_q <= `ESF_MASK_RESET;
      rdata <= 16'h0000;
      rvalid <= 1'b0;
      group_pending <= 5'h00;
    end else begin
      oc_q <= oc_d;
      pin_q <= pin_d;
      cw_q <= cw_d;
      mask_q <= mask_d;
      rdata <= rdata_d;
      rvalid <= rvalid_d;
      group_pending <= pend_d;
    end
  end

endmodule

// File: test/esf_flags_properties.sv
// port assertions for the event status flags
`timescale 1ns/1ps
module esf_flags_checker (
  input wire logic clock,
  input wire logic rst_b,
  input wire esf_pkg::esf_bus_t bus,
  input wire logic overcurrent,
  input wire logic [12:0] pin_event,
  input wire esf_pkg::esf_level_t level_in,
  input wire esf_pkg::esf_wake_t wake_in,
  input wire logic [15:0] rdata,
  input wire logic rvalid,
  input wire logic [4:0] group_pending
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence rd_oc; bus.rd && bus.addr == 8'h1D; endsequence
  sequence rd_pin; bus.rd && bus.addr == 8'h1E; endsequence
  sequence rd_cw; bus.rd && bus.addr == 8'h1F; endsequence
  sequence oc_quiet; rd_oc ##0 !$rose(overcurrent); endsequence
  a_read_answer: assert property (bus.rd |=> rvalid) else $error("no answer");
  a_idle_zero: assert property (!rvalid |-> rdata == 16'h0000) else $error("idle data");
  a_oc_latch: assert property ($rose(overcurrent) ##1 !(bus.rd && bus.addr == 8'h1D) ##1 rd_oc |=> rdata[15])
    else $error("oc flag lost");
  a_read_clear: assert property (oc_quiet ##1 oc_quiet |=> !rdata[15])
    else $error("flag not cleared");
  a_oc_spare: assert property (rd_oc |=> rdata[14:0] == 15'h0000) else $error("spare set");
  a_pin_latch: assert property (pin_event[0] ##1 !(bus.rd && bus.addr == 8'h1E) [*3] ##1 rd_pin |=> rdata[0])
    else $error("pin lost");
  a_supply_change: assert property ($changed(level_in.usb) ##1 !(bus.rd && bus.addr == 8'h1F) [*4] ##1 rd_cw |=> rdata[15])
    else $error("supply change lost");
  a_wake_rise: assert property ($rose(wake_in.from_off) ##1 !(bus.rd && bus.addr == 8'h1F) [*4] ##1 rd_cw |=> rdata[6] && !rdata[7])
    else $error("wake flag wrong");
endmodule
bind esf_event_status_flags esf_flags_checker chk (.clock(clock), .rst_b(rst_b), .bus(bus),
  .overcurrent(overcurrent), .pin_event(pin_event), .level_in(level_in), .wake_in(wake_in),
  .rdata(rdata), .rvalid(rvalid), .group_pending(group_pending));

// File: test/esf_host_model.sv
// host model issuing register reads and writes
`timescale 1ns/1ps
module esf_host_model (
  input wire logic clock,
  output esf_pkg::esf_bus_t bus
);
  initial bus = '0;
  // call at a rising edge; without last the next request follows back to back
  task automatic access(input esf_pkg::esf_bus_t req, input bit last);
    bus <= req;
    @(posedge clock);
    if (last) bus <= '{1'b0, 1'b0, ~req.addr, ~req.wdata};
  endtask
endmodule

// File: test/test_event_status_flags.sv
// self-checking bench for the event status flags
`timescale 1ns/1ps
module test_event_status_flags;
  logic clock, rst_b, overcurrent, rvalid;
  logic [12:0] pin_event, pins;
  esf_pkg::esf_level_t level_in;
  esf_pkg::esf_wake_t wake_in;
  esf_pkg::esf_bus_t bus;
  logic [15:0] rdata;
  logic [4:0] group_pending;
  logic [6:0] lv, wk;
  logic [15:0] exp_q[$];
  int miscompares = 0, samples_checked = 0, cycles = 0, seed = 29595;
  esf_event_status_flags uut (.clock(clock), .rst_b(rst_b), .bus(bus), .overcurrent(overcurrent),
    .pin_event(pin_event), .level_in(level_in), .wake_in(wake_in), .rdata(rdata),
    .rvalid(rvalid), .group_pending(group_pending));
  esf_host_model host (.clock(clock), .bus(bus));
  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: read %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_pend(input logic [4:0] got, input logic [4:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: pending %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input bit last);
    exp_q.push_back(e);
    host.access('{1'b1, 1'b0, a, 16'h0000}, last);
  endtask
  task complete_run;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) cmp(rdata, 16'hFFFF);
      else cmp(rdata, exp_q.pop_front());
    end
    if (cycles == 1000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    rst_b = 0;
    overcurrent = 0;
    pin_event = '0;
    level_in = '0;
    wake_in = '0;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rd(8'h20, 16'h001F, 1'b0);
    host.access('{1'b0, 1'b1, 8'h1D, 16'hFFFF}, 1'b0);
    rd(8'h1D, 16'h0000, 1'b0);
    rd(8'h40, 16'h0000, 1'b1);
    for (int r = 0; r < 2; r++) begin
      @(posedge clock);
      if (r == 1) begin
        host.access('{1'b0, 1'b1, 8'h20, 16'hFFE0}, 1'b0);
        rd(8'h20, 16'h0000, 1'b1);
      end
      pins = 13'($random(seed)) | 13'h0001;
      lv = 7'($random(seed)) | 7'h48;
      wk = 7'($random(seed)) | 7'h40;
      overcurrent <= 1'b1;
      pin_event <= pins;
      level_in <= level_in ^ lv;
      wake_in <= wk;
      @(posedge clock);
      overcurrent <= 1'b0;
      pin_event <= '0;
      wake_in <= '0;
      @(negedge clock);
      cmp_pend(group_pending, r == 1 ? 5'h1F : 5'h00);
      @(posedge clock);
      rd(8'h1D, 16'h8000, 1'b0);
      rd(8'h1D, 16'h0000, 1'b0);
      rd(8'h1E, {3'h0, pins}, 1'b0);
      rd(8'h1F, {lv[6:4], 1'b0, lv[3:0], 1'b0, wk}, 1'b0);
      rd(8'h1F, 16'h0000, 1'b1);
    end
    repeat (3) @(posedge clock);
    if (exp_q.size() != 0) miscompares++;
    complete_run();
  end
endmodule
